// >>> rtl/efm_pkg.sv
// Purpose: constants for the engine fault monitor
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes:   fault vector bit positions are fixed by the code lookup
package efm_pkg;
	localparam int          NUM_FLT          = 31;
	localparam int          FLT_OIL_NET      = 20;
	localparam int          AXI_AW           = 8;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0]  ADDR_STATUS      = 8'h00;
	localparam logic [7:0]  ADDR_ACTIVE      = 8'h04;
	localparam logic [7:0]  ADDR_STORED      = 8'h08;
	localparam logic [7:0]  ADDR_LATCH       = 8'h0C;
	localparam logic [7:0]  ADDR_DELAY       = 8'h10;
	localparam logic [7:0]  ADDR_WARN        = 8'h14;
	localparam logic [7:0]  ADDR_CLEAR       = 8'h18;
	localparam logic [7:0]  ADDR_QUERY       = 8'h1C;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	localparam logic [30:0] LATCH_RST        = 31'h0000_0000;
	localparam logic [15:0] LAMP_DELAY_RST   = 16'h0000;
	localparam logic [15:0] LAMP_DELAY_MAX   = 16'hEA60;
	localparam int          W_OVERTEMP       = 0;
	localparam int          W_LOW_VOLT       = 1;
	localparam int          W_GEN1           = 2;
	localparam int          W_GEN2           = 3;
	localparam int          W_LOW_OIL        = 4;
	// ****************************************************************
	// trouble code numbers
	// ****************************************************************
	localparam logic [7:0]  CODE_COOLANT_HI  = 8'h0E;
	localparam logic [7:0]  CODE_COOLANT_LO  = 8'h0F;
	localparam logic [7:0]  CODE_THROT_HI    = 8'h15;
	localparam logic [7:0]  CODE_THROT_LO    = 8'h16;
	localparam logic [7:0]  CODE_IAT_HI      = 8'h17;
	localparam logic [7:0]  CODE_IAT_LO      = 8'h19;
	localparam logic [7:0]  CODE_MAP_HI      = 8'h21;
	localparam logic [7:0]  CODE_MAP_LO      = 8'h22;
	localparam logic [7:0]  CODE_IGN         = 8'h29;
	localparam logic [7:0]  CODE_KNOCK       = 8'h2C;
	localparam logic [7:0]  CODE_CHECKSUM    = 8'h33;
	localparam logic [7:0]  CODE_OIL_CAT     = 8'h51;
	// ****************************************************************
	// thresholds and timing
	// ****************************************************************
	localparam logic signed [9:0] OVERTEMP_F = 10'h0DC;
	localparam logic [7:0]  LOW_VOLT_DV      = 8'h64;
	localparam logic [7:0]  OIL_LOW_PSI      = 8'h0A;
	localparam logic [13:0] RPM_REDUCE_ON    = 14'h07D0;
	localparam logic [13:0] RPM_REDUCE_OFF   = 14'h04B0;
	localparam logic [5:0]  AGE_STARTS       = 6'h32;
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          TICK_PERIOD_NS   = 1000000;
	localparam int          TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// >>> rtl/efm_fault_monitor.sv
// Purpose: fault lamp, stored trouble codes, logged warnings, power reduction
// Assumes: fault flags and engine data are synchronous to aclk
// Notes:   aresetn is power-on reset; ignition_on marks each ignition cycle
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - lamp lit while any malfunction present
// - lamp off when fault clears, code kept
// - erase code after 50 clean engine starts
// - lamp delay calibratable, immediate to one minute
// - latching code holds lamp whole ignition cycle
// - refuse clearing latching code set this cycle
// - coolant codes 14/15, intake air 23/25
// - throttle codes 21/22, manifold pressure 33/34
// - code 41 per ignition channel A-H
// - code 44 per knock input 1, 2
// - code 51 on calibration checksum mismatch
// - code 81 on exhaust overtemperature switch
// - code 81 crank, cam, supply, reference faults
// - code 81 fuel pump relay high, low/open
// - code 81 injector banks A/B high, low/open
// - warnings never light lamp
// - warnings cleared like trouble codes
// - coolant over 220F: warning plus reduction
// - supply under 10V: warning only
// - trans/oil switch closed: warning plus reduction
// - network oil under 10psi: warning, reduction, 81
// - reduction above 2000rpm, restore below 1200rpm
// - reduction fires only one injector bank
module efm_fault_monitor
	import efm_pkg::*;
#(
	parameter int unsigned TICK_CYC = efm_pkg::TICK_CYCLES
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [efm_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output      logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output      logic                       s_axi_wready,
	output      logic [1:0]                 s_axi_bresp,
	output      logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [efm_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output      logic                       s_axi_arready,
	output      logic [31:0]                s_axi_rdata,
	output      logic [1:0]                 s_axi_rresp,
	output      logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [30:0]                fault_flags,
	input  wire logic                       oil_net_present,
	input  wire logic [7:0]                 oil_psi,
	input  wire logic signed [9:0]          coolant_temp_f,
	input  wire logic [7:0]                 supply_dv,
	input  wire logic                       trans_sw_closed,
	input  wire logic                       oil_sw_closed,
	input  wire logic [13:0]                engine_rpm,
	input  wire logic                       engine_start,
	input  wire logic                       ignition_on,
	output      logic                       fault_lamp,
	output      logic                       reduction_active,
	output      logic                       inj_bank_a_en,
	output      logic                       inj_bank_b_en
);
	import efm_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [16:0]       tick_cnt;
		logic              tick;
		logic [30:0][15:0] dly_cnt;
		logic [30:0][5:0]  age;
		logic [30:0]       qual;
		logic [30:0]       stored;
		logic [30:0]       recur;
		logic [30:0]       cycle_set;
		logic [30:0]       lamp_latch;
		logic [30:0]       latch_class;
		logic [4:0]        warn;
		logic [15:0]       lamp_delay;
		logic [4:0]        query_idx;
		logic              reduce;
		logic              lamp;
		logic              refused;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} efm_state_t;

	efm_state_t s_reg;
	efm_state_t s_next;
	logic [30:0] cond;
	logic [30:0] qnow;
	logic [30:0] keep;
	logic [4:0]  warn_now;
	logic        oil_low;
	logic        reduce_en;
	logic        wr_go;
	logic        rd_go;
	logic        clr;
	logic [31:0] wtmp;

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// returns {sub-index, code number} for a fault bit position
	function automatic logic [15:0] code_of(input logic [4:0] idx);
		logic [15:0] r;
		r = 16'h0000;
		unique case (idx) inside
			5'd0:        r = {8'h00, CODE_COOLANT_HI};
			5'd1:        r = {8'h00, CODE_COOLANT_LO};
			5'd4:        r = {8'h00, CODE_IAT_HI};
			5'd5:        r = {8'h00, CODE_IAT_LO};
			5'd2:        r = {8'h00, CODE_THROT_HI};
			5'd3:        r = {8'h00, CODE_THROT_LO};
			5'd6:        r = {8'h00, CODE_MAP_HI};
			5'd7:        r = {8'h00, CODE_MAP_LO};
			[5'd8:5'd15]: r = {3'h0, idx - 5'd8, CODE_IGN};
			[5'd16:5'd17]: r = {3'h0, idx - 5'd16, CODE_KNOCK};
			5'd18:       r = {8'h00, CODE_CHECKSUM};
			5'd19:       r = {8'h00, CODE_OIL_CAT};
			5'd20:       r = {8'h01, CODE_OIL_CAT};
			[5'd21:5'd24]: r = {3'h0, idx - 5'd19, CODE_OIL_CAT};
			[5'd25:5'd26]: r = {3'h0, idx - 5'd19, CODE_OIL_CAT};
			[5'd27:5'd30]: r = {3'h0, idx - 5'd19, CODE_OIL_CAT};
			default:     r = 16'h0000;
		endcase
		return r;
	endfunction

	assign s_axi_awready    = wr_go;
	assign s_axi_wready     = wr_go;
	assign s_axi_bvalid     = s_reg.bvalid;
	assign s_axi_bresp      = s_reg.bresp;
	assign s_axi_arready    = ~s_reg.rvalid;
	assign s_axi_rvalid     = s_reg.rvalid;
	assign s_axi_rresp      = s_reg.rresp;
	assign s_axi_rdata      = s_reg.rdata;
	assign fault_lamp       = s_reg.lamp;
	assign reduction_active = s_reg.reduce;
	// bank a always fires; reduction drops bank b only
	assign inj_bank_a_en    = 1'b1;
	assign inj_bank_b_en    = ~s_reg.reduce;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		wr_go = s_axi_awvalid & s_axi_wvalid & ~s_reg.bvalid;
		rd_go = s_axi_arvalid & ~s_reg.rvalid;
		clr = wr_go && (s_axi_awaddr == ADDR_CLEAR) && s_axi_wstrb[0] && s_axi_wdata[0];
		wtmp = 32'h0000_0000;
		// 1 ms tick for the lamp delay
		if (s_reg.tick_cnt == 17'(TICK_CYC - 1)) begin
			s_next.tick_cnt = 17'h00000;
			s_next.tick = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 17'h00001;
			s_next.tick = 1'b0;
		end
		oil_low = oil_net_present && (oil_psi < OIL_LOW_PSI);
		cond = fault_flags;
		cond[FLT_OIL_NET] = fault_flags[FLT_OIL_NET] | oil_low;
		// fault qualification after the calibrated delay
		for (int i = 0; i < NUM_FLT; i++) begin
			qnow[i] = cond[i] && (s_reg.dly_cnt[i] >= s_reg.lamp_delay);
			if (!cond[i]) begin
				s_next.dly_cnt[i] = 16'h0000;
			// counter freezes once qualified, so it cannot wrap
			end else if (!qnow[i] && s_reg.tick) begin
				s_next.dly_cnt[i] = s_reg.dly_cnt[i] + 16'h0001;
			end
		end
		s_next.qual = qnow;
		// aging over engine starts
		if (engine_start) begin
			for (int i = 0; i < NUM_FLT; i++) begin
				if (s_reg.stored[i]) begin
					if (s_reg.recur[i]) begin
						s_next.age[i] = 6'h00;
					end else if (s_reg.age[i] == AGE_STARTS - 6'h01) begin
						s_next.stored[i] = 1'b0;
						s_next.age[i] = 6'h00;
					end else begin
						s_next.age[i] = s_reg.age[i] + 6'h01;
					end
				end
			end
			s_next.recur = 31'h0000_0000;
		end
		// clear request; latching codes of this cycle survive
		keep = s_reg.latch_class & s_reg.cycle_set;
		if (clr) begin
			s_next.stored = s_next.stored & keep;
			s_next.warn = 5'h00;
			s_next.refused = |(s_reg.stored & keep);
			for (int i = 0; i < NUM_FLT; i++) begin
				if (!keep[i]) begin
					s_next.age[i] = 6'h00;
				end
			end
		end
		if (ignition_on) begin
			s_next.cycle_set = 31'h0000_0000;
			s_next.lamp_latch = 31'h0000_0000;
		end
		// new events win over any clear in the same cycle
		s_next.stored = s_next.stored | qnow;
		s_next.recur = s_next.recur | qnow;
		s_next.cycle_set = s_next.cycle_set | qnow;
		s_next.lamp_latch = s_next.lamp_latch | (qnow & s_reg.latch_class);
		for (int i = 0; i < NUM_FLT; i++) begin
			if (qnow[i]) begin
				s_next.age[i] = 6'h00;
			end
		end
		s_next.lamp = |s_next.qual | |s_next.lamp_latch;
		// logged warnings
		warn_now[W_OVERTEMP] = coolant_temp_f > OVERTEMP_F;
		warn_now[W_LOW_VOLT] = supply_dv < LOW_VOLT_DV;
		warn_now[W_GEN1] = trans_sw_closed;
		warn_now[W_GEN2] = oil_sw_closed;
		warn_now[W_LOW_OIL] = oil_low;
		s_next.warn = s_next.warn | warn_now;
		reduce_en = warn_now[W_OVERTEMP] | warn_now[W_GEN1] | warn_now[W_GEN2] | warn_now[W_LOW_OIL];
		// hysteresis: between the two speeds the mode holds
		if (engine_rpm < RPM_REDUCE_OFF) begin
			s_next.reduce = 1'b0;
		end else if (reduce_en && (engine_rpm > RPM_REDUCE_ON)) begin
			s_next.reduce = 1'b1;
		end
		// ************************************************************
		// register bus
		// ************************************************************
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			unique case (s_axi_awaddr)
				ADDR_LATCH: begin
					wtmp = wmerge({1'b0, s_reg.latch_class}, s_axi_wdata, s_axi_wstrb);
					s_next.latch_class = wtmp[30:0];
				end
				ADDR_DELAY: begin
					wtmp = wmerge({16'h0000, s_reg.lamp_delay}, s_axi_wdata, s_axi_wstrb);
					s_next.lamp_delay = (wtmp[15:0] > LAMP_DELAY_MAX) ? LAMP_DELAY_MAX : wtmp[15:0];
				end
				ADDR_QUERY: begin
					wtmp = wmerge({27'h0000000, s_reg.query_idx}, s_axi_wdata, s_axi_wstrb);
					s_next.query_idx = wtmp[4:0];
				end
				ADDR_STATUS, ADDR_ACTIVE, ADDR_STORED, ADDR_WARN, ADDR_CLEAR: begin
					s_next.bresp = RESP_OKAY;
				end
				default: s_next.bresp = RESP_SLVERR;
			endcase
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_STATUS: s_next.rdata = {28'h0000000, s_reg.refused, reduce_en, s_reg.reduce, s_reg.lamp};
				ADDR_ACTIVE: s_next.rdata = {1'b0, cond};
				ADDR_STORED: s_next.rdata = {1'b0, s_reg.stored};
				ADDR_LATCH:  s_next.rdata = {1'b0, s_reg.latch_class};
				ADDR_DELAY:  s_next.rdata = {16'h0000, s_reg.lamp_delay};
				ADDR_WARN:   s_next.rdata = {27'h0000000, s_reg.warn};
				ADDR_CLEAR:  s_next.rdata = 32'h0000_0000;
				ADDR_QUERY:  s_next.rdata = {11'h000, s_reg.query_idx, code_of(s_reg.query_idx)};
				default: begin
					s_next.rdata = 32'h0000_0000;
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.latch_class <= LATCH_RST;
			s_reg.lamp_delay <= LAMP_DELAY_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_lamp_immediate: assert property ((s_reg.lamp_delay == 16'h0000 && |cond) |=> fault_lamp)
		else $error("lamp not lit for present fault");
	a_lamp_goes_out: assert property ((cond == 31'h0 && s_reg.lamp_latch == 31'h0 && !ignition_on) |=> !fault_lamp)
		else $error("lamp lit with no fault and no latch");
	a_code_kept: assert property ((s_reg.stored[0] && !clr && !engine_start) |=> s_reg.stored[0])
		else $error("stored code lost");
	a_age_erase: assert property ((engine_start && s_reg.stored[5] && !s_reg.recur[5] && !qnow[5]
		&& s_reg.age[5] == 6'h31) |=> !s_reg.stored[5])
		else $error("code not erased after clean starts");
	a_delay_hold: assert property (($rose(cond[3]) && s_reg.lamp_delay != 16'h0000) |=> !s_reg.qual[3])
		else $error("fault qualified before delay");
	a_latch_lamp: assert property ((|s_reg.lamp_latch && !ignition_on)
		|=> (fault_lamp && |s_reg.lamp_latch) ##1 (fault_lamp || $past(ignition_on)))
		else $error("latched lamp went out");
	a_latch_refuse: assert property ((clr && !engine_start && |(s_reg.stored & keep))
		|=> s_reg.refused
		&& ((s_reg.stored & $past(keep) & $past(s_reg.stored)) == ($past(keep) & $past(s_reg.stored))))
		else $error("latching code cleared in its cycle");
	a_warn_logged: assert property ((coolant_temp_f > OVERTEMP_F && !clr)
		|=> s_reg.warn[W_OVERTEMP] ##1 (s_reg.warn[W_OVERTEMP] || $past(clr)))
		else $error("overtemp warning not logged");
	a_reduce_on: assert property ((reduce_en && engine_rpm > RPM_REDUCE_ON) |=> reduction_active && !inj_bank_b_en)
		else $error("reduction not entered above upper speed");
	a_reduce_off: assert property ((engine_rpm < RPM_REDUCE_OFF) |=> !reduction_active && inj_bank_b_en)
		else $error("reduction not released below lower speed");

	// ****************************************************************
	// warnings, reduction, storage, lamp latch and delay
	// ****************************************************************
	a_warn_no_lamp: assert property ((|warn_now && cond == 31'h0 && s_reg.lamp_latch == 31'h0)
		|=> !fault_lamp)
		else $error("warning lit the lamp");
	a_warn_clear: assert property ((clr && warn_now == 5'h00) |=> s_reg.warn == 5'h00)
		else $error("warnings survived a clear");
	a_low_volt_only: assert property ((warn_now == 5'h02 && !s_reg.reduce)
		|=> !reduction_active && s_reg.warn[W_LOW_VOLT])
		else $error("low voltage handled wrongly");
	a_gen1_warn: assert property (trans_sw_closed |=> s_reg.warn[W_GEN1])
		else $error("general warning 1 not logged");
	a_gen2_warn: assert property (oil_sw_closed |=> s_reg.warn[W_GEN2])
		else $error("general warning 2 not logged");
	a_net_oil: assert property ((oil_net_present && oil_psi < OIL_LOW_PSI && s_reg.lamp_delay == 16'h0000)
		|=> s_reg.stored[FLT_OIL_NET] && s_reg.warn[W_LOW_OIL])
		else $error("network low oil not recorded");
	a_bank_pair: assert property (inj_bank_a_en && (inj_bank_b_en != reduction_active))
		else $error("injector bank enables wrong");
	a_latch_set: assert property (|(qnow & s_reg.latch_class) |=> fault_lamp && |s_reg.lamp_latch)
		else $error("latching code did not latch lamp");
	a_reduce_hold: assert property ((s_reg.reduce && engine_rpm >= RPM_REDUCE_OFF) |=> reduction_active)
		else $error("reduction dropped above lower speed");
	a_reduce_idle: assert property ((!s_reg.reduce && engine_rpm <= RPM_REDUCE_ON) |=> !reduction_active)
		else $error("reduction entered at or below upper speed");
	a_store_on_qual: assert property (|qnow |=> (s_reg.stored & $past(qnow)) == $past(qnow))
		else $error("qualified fault not stored");
	a_delay_cap: assert property (s_reg.lamp_delay <= LAMP_DELAY_MAX)
		else $error("lamp delay above one minute");
	a_age_restart: assert property ((engine_start && s_reg.stored[5] && s_reg.recur[5]) |=> s_reg.age[5] == 6'h00)
		else $error("age not restarted after recurrence");
endmodule // efm_fault_monitor

// >>> dv/efm_engine_model.sv
// Purpose: engine side of the fault monitor: sensor flags and start pulses
// Assumes: the bench raises start_req for one engine start at a time
// Notes:   flags are re-timed to aclk; one start pulse per rise of start_req
`timescale 1ns/1ps
module efm_engine_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [30:0] flag_req,
	input  wire logic        start_req,
	output      logic [30:0] fault_flags,
	output      logic        engine_start
);
	logic start_prev;

	// flags synchronous to aclk, start as a one-cycle pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_flags  <= '0;
			engine_start <= 1'b0;
			start_prev   <= 1'b0;
		end else begin
			fault_flags  <= flag_req;
			engine_start <= start_req & ~start_prev;
			start_prev   <= start_req;
		end
	end
endmodule // efm_engine_model

// >>> dv/efm_fault_monitor_test.sv
// Purpose: self-checking bench for the engine fault monitor
// Assumes: TICK_CYC shortened to 4 cycles per lamp delay tick
// Notes:   read and write answers are checked against queued notes
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module efm_fault_monitor_test;
	import efm_pkg::*;
	logic               aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]         s_axi_awaddr, s_axi_araddr, oil_psi, supply_dv;
	logic [31:0]        s_axi_wdata, s_axi_rdata;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [30:0]        flag_req, fault_flags;
	logic               start_req, engine_start, oil_net_present, trans_sw_closed, oil_sw_closed, ignition_on;
	logic               fault_lamp, reduction_active, inj_bank_a_en, inj_bank_b_en;
	logic signed [9:0]  coolant_temp_f;
	logic [13:0]        engine_rpm;
	logic [31:0]        seed = 32'h51CEE399;
	int                 n_fail, tests_run, k;
	logic [67:0]        note, rq[$];
	logic [1:0]         wnote, wq[$];
	logic [7:0]         ctab [0:18] = '{8'h0E, 8'h0F, 8'h15, 8'h16, 8'h17, 8'h19, 8'h21, 8'h22, 8'h29, 8'h29,
		8'h29, 8'h29, 8'h29, 8'h29, 8'h29, 8'h29, 8'h2C, 8'h2C, 8'h33};
	logic [4:0]         wtab [0:6] = '{5'h00, 5'h01, 5'h00, 5'h02, 5'h04, 5'h08, 5'h10};
	logic [2:0]         stab [0:6] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h4, 3'h4, 3'h5};
	logic [13:0]        rtab [0:5] = '{14'h0000, 14'h07D0, 14'h07D1, 14'h0000, 14'h04B0, 14'h04AF};
	logic [5:0]         etab = 6'h1C;

	efm_fault_monitor #(.TICK_CYC(4)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.fault_flags, .oil_net_present, .oil_psi, .coolant_temp_f, .supply_dv, .trans_sw_closed, .oil_sw_closed,
		.engine_rpm, .engine_start, .ignition_on, .fault_lamp, .reduction_active, .inj_bank_a_en, .inj_bank_b_en);
	efm_engine_model i_eng (.aclk, .aresetn, .flag_req, .start_req, .fault_flags, .engine_start);

	// ****************************************************************
	// helpers and bus tasks
	// ****************************************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic tmo(input int j);
		if (j >= 64) begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int j;
		wq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (j = 0; j < 64; j++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				break;
		end
		tmo(j);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		for (j = 0; j < 64; j++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1)
				break;
		end
		tmo(j);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r = 2'h0);
		int j;
		rq.push_back({r, e, 2'h3, m});
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (j = 0; j < 64; j++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				break;
		end
		tmo(j);
		s_axi_arvalid <= 1'b0;
		for (j = 0; j < 64; j++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1)
				break;
		end
		tmo(j);
		s_axi_rready <= 1'b0;
	endtask
	task automatic sett(input int i);
		coolant_temp_f  <= (i == 0) ? 10'h0DC : (i == 1) ? 10'h0DD : 10'h096;
		supply_dv       <= (i == 2) ? 8'h64 : (i == 3) ? 8'h63 : 8'h82;
		trans_sw_closed <= (i == 4);
		oil_sw_closed   <= (i == 5);
		oil_net_present <= (i == 6);
		oil_psi         <= (i == 6) ? 8'h09 : 8'h28;
	endtask
	task automatic st();
		start_req <= 1'b1;
		cyc(1);
		start_req <= 1'b0;
		cyc(2);
	endtask

	// ****************************************************************
	// answer monitor and stimulus
	// ****************************************************************
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			note = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata} & note[33:0], note[67:34] & note[33:0])
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
			wnote = wq.pop_front();
			`CHK(s_axi_bresp, wnote)
		end
	end
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, flag_req, start_req, ignition_on, engine_rpm} = '0;
		s_axi_wstrb = 4'hF;
		sett(7);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_STATUS, 32'h0, 32'hFFFFFFFF);
		rd(ADDR_LATCH, 32'h0, 32'hFFFFFFFF);
		`CHK(inj_bank_b_en, 1'b1)
		wr(ADDR_ACTIVE, xs());
		rd(ADDR_ACTIVE, 32'h0, 32'hFFFFFFFF);
		wr(8'h24, xs(), RESP_SLVERR);
		rd(8'h20, 32'h0, 32'h0, RESP_SLVERR);
		for (int i = 0; i < 32; i++) begin
			wr(ADDR_QUERY, 32'(i));
			if (i == 31)
				rd(ADDR_QUERY, 32'h001F_0000, 32'hFFFFFFFF);
			else if (i < 19)
				rd(ADDR_QUERY, {11'h0, i[4:0], 8'h00, ctab[i]}, 32'h001F00FF);
			else
				rd(ADDR_QUERY, {11'h0, i[4:0], 8'(i - 19), 8'h51}, 32'hFFFFFFFF);
		end
		flag_req <= 31'h1;
		cyc(3);
		`CHK(fault_lamp, 1'b1)
		cyc(20);
		`CHK(fault_lamp, 1'b1)
		flag_req <= 31'h0;
		cyc(3);
		`CHK(fault_lamp, 1'b0)
		rd(ADDR_STORED, 32'h1, 32'hFFFFFFFF);
		wr(ADDR_DELAY, 32'hFFFF);
		rd(ADDR_DELAY, 32'hEA60, 32'hFFFFFFFF);
		wr(ADDR_DELAY, 32'h3);
		flag_req <= 31'h8;
		cyc(6);
		`CHK(fault_lamp, 1'b0)
		for (k = 0; k < 40 && fault_lamp !== 1'b1; k++)
			@(posedge aclk);
		`CHK(k < 14, 1'b1)
		flag_req <= 31'h0;
		wr(ADDR_DELAY, 32'h0);
		wr(ADDR_LATCH, 32'h40000);
		flag_req <= 31'h40000;
		cyc(3);
		flag_req <= 31'h0;
		cyc(10);
		`CHK(fault_lamp, 1'b1)
		wr(ADDR_CLEAR, 32'h1);
		rd(ADDR_STATUS, 32'h8, 32'h8);
		rd(ADDR_STORED, 32'h40000, 32'hFFFFFFFF);
		ignition_on <= 1'b1;
		cyc(1);
		ignition_on <= 1'b0;
		cyc(3);
		`CHK(fault_lamp, 1'b0)
		wr(ADDR_CLEAR, 32'h1);
		rd(ADDR_STORED, 32'h0, 32'hFFFFFFFF);
		wr(ADDR_LATCH, 32'h0);
		for (int i = 0; i < 7; i++) begin
			sett(i);
			cyc(4);
			rd(ADDR_WARN, 32'(wtab[i]), 32'hFFFFFFFF);
			rd(ADDR_STATUS, 32'(stab[i]), 32'h7);
			if (i == 6)
				rd(ADDR_STORED, 32'h100000, 32'h100000);
			sett(7);
			cyc(3);
			wr(ADDR_CLEAR, 32'h1);
			rd(ADDR_WARN, 32'h0, 32'hFFFFFFFF);
		end
		supply_dv  <= 8'h63;
		engine_rpm <= 14'h0BB8;
		cyc(4);
		`CHK(reduction_active, 1'b0)
		supply_dv       <= 8'h82;
		trans_sw_closed <= 1'b1;
		for (int j = 0; j < 6; j++) begin
			engine_rpm <= (j == 0) ? 14'(xs() % 2000) : (j == 3) ? 14'(1200 + xs() % 800) : rtab[j];
			cyc(4);
			`CHK(reduction_active, etab[j])
			`CHK(inj_bank_b_en, ~etab[j])
			`CHK(inj_bank_a_en, 1'b1)
		end
		trans_sw_closed <= 1'b0;
		engine_rpm      <= 14'h0000;
		flag_req        <= 31'h20;
		cyc(3);
		flag_req <= 31'h0;
		cyc(3);
		repeat (50) st();
		rd(ADDR_STORED, 32'h20, 32'h20);
		st();
		rd(ADDR_STORED, 32'h0, 32'h20);
		conclude();
	end
endmodule // efm_fault_monitor_test
